// *** nvm_ctrl_pkg.sv ***
// Package: addresses, bit positions, reset values and types of the nonvolatile control block
package nvm_ctrl_pkg;

    localparam logic [15:0] OTP_CTRL_ADDR = 16'h000D;
    localparam logic [15:0] EE_CTRL_ADDR = 16'h000E;
    localparam logic [15:0] OPTION_ADDR = 16'h3C00;
    localparam logic [15:0] BOOT_START_ADDR = 16'h3C00;
    localparam logic [15:0] EE_BASE_ADDR = 16'h0240;
    localparam logic [15:0] EE_LAST_ADDR = 16'h033F;
    localparam logic [15:0] OTP_BASE_ADDR = 16'h1000;
    localparam logic [15:0] OTP_LAST_ADDR = 16'h3BFF;

    // Control register bit positions
    localparam int OTP_POWER_BIT = 0;
    localparam int OTP_LATCH_BIT = 1;
    localparam int OPTION_MAP_BIT = 2;
    localparam int EE_POWER_BIT = 0;
    localparam int EE_LATCH_BIT = 1;
    localparam int ERASE_LOW_BIT = 2;
    localparam int ERASE_HIGH_BIT = 3;
    localparam int PUMP_BIT = 4;
    localparam int RC_SEL_BIT = 5;

    // Option byte fields; other bits are unimplemented
    localparam int WATCHDOG_DISABLE_BIT = 0;
    localparam int LEVEL_SENSE_BIT = 1;
    localparam int STOP_ENABLE_BIT = 2;
    localparam int LVR_ENABLE_BIT = 3;
    localparam logic [7:0] OPTION_IMPL_MASK = 8'h0F;
    localparam logic [7:0] OPTION_ERASED = 8'h00;
    localparam logic [7:0] OTP_CTRL_MASK = 8'h07;
    localparam logic [7:0] EE_CTRL_MASK = 8'h3F;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] EE_ERASED = 8'hFF;
    localparam logic [7:0] BLOCK_MASK = 8'hC0;
    localparam logic [7:0] BOOT_FIRST_BYTE = 8'h00;

    typedef enum logic [1:0] {
        ERASE_NONE,
        ERASE_BYTE,
        ERASE_BLOCK,
        ERASE_BULK
    } erase_mode_t;

    typedef struct packed {
        logic lvr_enable;
        logic stop_enable;
        logic level_sense;
        logic watchdog_enable;
    } options_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] data;
        logic valid;
    } latch_t;

endpackage

// *** nvm_boot_detect.sv ***
// Bootloader mode capture at reset release
`timescale 1ns/1ps
module nvm_boot_detect (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic test_voltage_level_in,
    input wire logic boot_select_pin_in,
    output logic boot_mode_out
);
    logic armed_q;

    // Straps are caught by the first clocked edge after release
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            armed_q <= 1'b1;
            boot_mode_out <= 1'b0;
        end else if (armed_q) begin
            armed_q <= 1'b0;
            boot_mode_out <= test_voltage_level_in & boot_select_pin_in;
        end
    end
endmodule // nvm_boot_detect

// *** nvm_program_ctrl.sv ***
// Program and erase control for the one-time array, option byte and erasable array
// Function
// - Boot mode when test voltage and boot pin
// - Option map bit selects option byte or ROM
// - Option byte access only with map bit
// - OTP latch captures writes, blocks reads
// - Power needs latch; latch low clears power
// - Latch and power never set in one write
// - Erased option byte reads zero
// - Programming option byte disables all options
// - Stop enable and interrupt sense options
// - Low-voltage reset enable, inverted watchdog bit
// - Reset aborts erasable array write
// - Pump enable read/write, cleared by reset
// - Two-bit erase select, cleared by reset
// - Byte, 64-byte block, 256-byte bulk erase
// - Erasable latch captures writes, blocks reads once a write is latched
// - RC clock select, cleared by reset
// - Erasable power writable only with latch
// - Stop entry turns off RC oscillator
`timescale 1ns/1ps
module nvm_program_ctrl (
    input wire logic CLK_IN,
    input wire logic RST_IN,
    input wire logic [15:0] ADDR_IN,
    input wire logic [7:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    input wire logic TEST_VOLTAGE_LEVEL_IN,
    input wire logic BOOT_SELECT_PIN_IN,
    input wire logic STOP_ENTRY_IN,
    input wire logic [7:0] OTP_RDATA_IN,
    output logic [7:0] RDATA_OUT,
    output logic BOOT_MODE_OUT,
    output logic [15:0] BOOT_VECTOR_OUT,
    output logic OTP_PROGRAM_POWER_OUT,
    output logic [15:0] OTP_PGM_ADDR_OUT,
    output logic [7:0] OTP_PGM_DATA_OUT,
    output logic OPTION_PGM_OUT,
    output logic PUMP_ENABLE_OUT,
    output logic ERASABLE_POWER_OUT,
    output logic RC_OSC_ENABLE_OUT,
    output logic LVR_ENABLE_OUT,
    output logic STOP_ENABLE_OUT,
    output logic LEVEL_SENSE_OUT,
    output logic WATCHDOG_ENABLE_OUT
);
    logic [7:0] otp_ctrl_q;
    logic [7:0] ee_ctrl_q;
    logic [7:0] option_q;
    logic [7:0] ee_mem_q [0:255];
    nvm_ctrl_pkg::latch_t otp_lat_q;
    nvm_ctrl_pkg::latch_t ee_lat_q;
    nvm_ctrl_pkg::options_t opt_d;
    nvm_ctrl_pkg::erase_mode_t mode_d;
    logic otp_latch;
    logic otp_power;
    logic option_map;
    logic ee_latch;
    logic ee_power;
    logic boot_mode;
    logic [7:0] rdata_d;

    function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                      input logic [15:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    function automatic logic [7:0] ee_index(input logic [15:0] a);
        logic [15:0] off;
        off = a - nvm_ctrl_pkg::EE_BASE_ADDR;
        ee_index = off[7:0];
    endfunction

    assign otp_latch = otp_ctrl_q[nvm_ctrl_pkg::OTP_LATCH_BIT];
    assign otp_power = otp_ctrl_q[nvm_ctrl_pkg::OTP_POWER_BIT];
    assign option_map = otp_ctrl_q[nvm_ctrl_pkg::OPTION_MAP_BIT];
    assign ee_latch = ee_ctrl_q[nvm_ctrl_pkg::EE_LATCH_BIT];
    assign ee_power = ee_ctrl_q[nvm_ctrl_pkg::EE_POWER_BIT];
    assign mode_d = nvm_ctrl_pkg::erase_mode_t'(ee_ctrl_q[nvm_ctrl_pkg::ERASE_HIGH_BIT -: 2]);

    nvm_boot_detect u_boot (
        .clk_in(CLK_IN),
        .rst_in(RST_IN),
        .test_voltage_level_in(TEST_VOLTAGE_LEVEL_IN),
        .boot_select_pin_in(BOOT_SELECT_PIN_IN),
        .boot_mode_out(boot_mode)
    );

    // One-time array control register
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            otp_ctrl_q <= nvm_ctrl_pkg::CTRL_RESET;
        end else if (WR_IN && ADDR_IN == nvm_ctrl_pkg::OTP_CTRL_ADDR) begin
            otp_ctrl_q <= WDATA_IN & nvm_ctrl_pkg::OTP_CTRL_MASK;
            // Power only takes when latch was already set, so both never set in one write
            if (!otp_latch || !WDATA_IN[nvm_ctrl_pkg::OTP_LATCH_BIT]) begin
                otp_ctrl_q[nvm_ctrl_pkg::OTP_POWER_BIT] <= 1'b0;
            end
        end else if (!otp_latch) begin
            otp_ctrl_q[nvm_ctrl_pkg::OTP_POWER_BIT] <= 1'b0;
        end
    end

    // One-time array and option byte write capture
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            otp_lat_q <= '0;
        end else if (!otp_latch) begin
            otp_lat_q.valid <= 1'b0;
        end else if (WR_IN && !otp_power) begin
            if (in_range(ADDR_IN, nvm_ctrl_pkg::OTP_BASE_ADDR, nvm_ctrl_pkg::OTP_LAST_ADDR)
                || (option_map && ADDR_IN == nvm_ctrl_pkg::OPTION_ADDR)) begin
                otp_lat_q.addr <= ADDR_IN;
                otp_lat_q.data <= WDATA_IN;
                otp_lat_q.valid <= 1'b1;
            end
        end
    end

    // Option cells program only while power is on; erased cells read zero
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            option_q <= nvm_ctrl_pkg::OPTION_ERASED;
        end else if (otp_power && otp_lat_q.valid && option_map
                     && otp_lat_q.addr == nvm_ctrl_pkg::OPTION_ADDR) begin
            option_q <= option_q | (otp_lat_q.data & nvm_ctrl_pkg::OPTION_IMPL_MASK);
        end
    end

    // Erasable array control register
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            ee_ctrl_q <= nvm_ctrl_pkg::CTRL_RESET;
        end else begin
            if (WR_IN && ADDR_IN == nvm_ctrl_pkg::EE_CTRL_ADDR) begin
                ee_ctrl_q[nvm_ctrl_pkg::RC_SEL_BIT:nvm_ctrl_pkg::EE_LATCH_BIT] <=
                    WDATA_IN[nvm_ctrl_pkg::RC_SEL_BIT:nvm_ctrl_pkg::EE_LATCH_BIT];
                if (ee_latch) begin
                    ee_ctrl_q[nvm_ctrl_pkg::EE_POWER_BIT] <=
                        WDATA_IN[nvm_ctrl_pkg::EE_POWER_BIT];
                end
            end
            if (STOP_ENTRY_IN) begin
                ee_ctrl_q[nvm_ctrl_pkg::RC_SEL_BIT] <= 1'b0;
            end
        end
    end

    // Erasable array write capture; reads blocked once a write is latched
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            ee_lat_q <= '0;
        end else if (!ee_latch) begin
            ee_lat_q.valid <= 1'b0;
        end else if (WR_IN && !ee_power
                     && in_range(ADDR_IN, nvm_ctrl_pkg::EE_BASE_ADDR,
                                 nvm_ctrl_pkg::EE_LAST_ADDR)) begin
            ee_lat_q.addr <= ADDR_IN;
            ee_lat_q.data <= WDATA_IN;
            ee_lat_q.valid <= 1'b1;
        end
    end

    // Cell update each cycle power is held; no pulse timer in hardware
    always_ff @(posedge CLK_IN) begin
        if (!RST_IN && ee_power && ee_lat_q.valid) begin
            for (int i = 0; i < 256; i++) begin
                case (mode_d)
                    nvm_ctrl_pkg::ERASE_NONE: begin
                        if (8'(i) == ee_index(ee_lat_q.addr)) begin
                            ee_mem_q[i] <= ee_mem_q[i] & ee_lat_q.data;
                        end
                    end
                    nvm_ctrl_pkg::ERASE_BYTE: begin
                        if (8'(i) == ee_index(ee_lat_q.addr)) begin
                            ee_mem_q[i] <= nvm_ctrl_pkg::EE_ERASED;
                        end
                    end
                    nvm_ctrl_pkg::ERASE_BLOCK: begin
                        if ((8'(i) & nvm_ctrl_pkg::BLOCK_MASK)
                            == (ee_index(ee_lat_q.addr) & nvm_ctrl_pkg::BLOCK_MASK)) begin
                            ee_mem_q[i] <= nvm_ctrl_pkg::EE_ERASED;
                        end
                    end
                    nvm_ctrl_pkg::ERASE_BULK: begin
                        ee_mem_q[i] <= nvm_ctrl_pkg::EE_ERASED;
                    end
                    default: begin
                        ee_mem_q[i] <= ee_mem_q[i];
                    end
                endcase
            end
        end
    end

    // Options all off while the option byte itself is being programmed
    always_comb begin
        if (option_map && otp_latch && otp_power) begin
            opt_d = '0;
            opt_d.watchdog_enable = 1'b0;
        end else begin
            opt_d.lvr_enable = option_q[nvm_ctrl_pkg::LVR_ENABLE_BIT];
            opt_d.stop_enable = option_q[nvm_ctrl_pkg::STOP_ENABLE_BIT];
            opt_d.level_sense = option_q[nvm_ctrl_pkg::LEVEL_SENSE_BIT];
            opt_d.watchdog_enable = !option_q[nvm_ctrl_pkg::WATCHDOG_DISABLE_BIT];
        end
    end

    // Read mux
    always_comb begin
        rdata_d = 8'h00;
        if (ADDR_IN == nvm_ctrl_pkg::OTP_CTRL_ADDR) begin
            rdata_d = otp_ctrl_q;
        end else if (ADDR_IN == nvm_ctrl_pkg::EE_CTRL_ADDR) begin
            rdata_d = ee_ctrl_q;
        end else if (ADDR_IN == nvm_ctrl_pkg::OPTION_ADDR) begin
            rdata_d = option_map ? (option_q & nvm_ctrl_pkg::OPTION_IMPL_MASK)
                                 : nvm_ctrl_pkg::BOOT_FIRST_BYTE;
        end else if (in_range(ADDR_IN, nvm_ctrl_pkg::EE_BASE_ADDR,
                              nvm_ctrl_pkg::EE_LAST_ADDR)) begin
            rdata_d = (ee_latch && ee_lat_q.valid) ? 8'h00
                                                   : ee_mem_q[ee_index(ADDR_IN)];
        end else if (in_range(ADDR_IN, nvm_ctrl_pkg::OTP_BASE_ADDR,
                              nvm_ctrl_pkg::OTP_LAST_ADDR)) begin
            rdata_d = otp_latch ? 8'h00 : OTP_RDATA_IN;
        end
    end

    // Read data: valid in the cycle after the strobe only
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            RDATA_OUT <= 8'h00;
        end else begin
            RDATA_OUT <= RD_IN ? rdata_d : 8'h00;
        end
    end

    // Registered outputs
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            BOOT_MODE_OUT <= 1'b0;
            BOOT_VECTOR_OUT <= 16'h0000;
            OTP_PROGRAM_POWER_OUT <= 1'b0;
            OTP_PGM_ADDR_OUT <= 16'h0000;
            OTP_PGM_DATA_OUT <= 8'h00;
            OPTION_PGM_OUT <= 1'b0;
            PUMP_ENABLE_OUT <= 1'b0;
            ERASABLE_POWER_OUT <= 1'b0;
            RC_OSC_ENABLE_OUT <= 1'b0;
            LVR_ENABLE_OUT <= 1'b0;
            STOP_ENABLE_OUT <= 1'b0;
            LEVEL_SENSE_OUT <= 1'b0;
            WATCHDOG_ENABLE_OUT <= 1'b0;
        end else begin
            BOOT_MODE_OUT <= boot_mode;
            BOOT_VECTOR_OUT <= boot_mode ? nvm_ctrl_pkg::BOOT_START_ADDR : 16'h0000;
            OTP_PROGRAM_POWER_OUT <= otp_power && otp_latch;
            OTP_PGM_ADDR_OUT <= otp_lat_q.addr;
            OTP_PGM_DATA_OUT <= otp_lat_q.data;
            OPTION_PGM_OUT <= option_map && otp_power;
            PUMP_ENABLE_OUT <= ee_ctrl_q[nvm_ctrl_pkg::PUMP_BIT];
            // Voltage reaches the array only with pump and power together
            ERASABLE_POWER_OUT <= ee_power && ee_ctrl_q[nvm_ctrl_pkg::PUMP_BIT];
            RC_OSC_ENABLE_OUT <= ee_ctrl_q[nvm_ctrl_pkg::RC_SEL_BIT] && !STOP_ENTRY_IN;
            LVR_ENABLE_OUT <= opt_d.lvr_enable;
            STOP_ENABLE_OUT <= opt_d.stop_enable;
            LEVEL_SENSE_OUT <= opt_d.level_sense;
            WATCHDOG_ENABLE_OUT <= opt_d.watchdog_enable;
        end
    end
endmodule // nvm_program_ctrl

// *** nvm_program_ctrl_properties.sv ***
// Checker of the program control block, seen from its ports
`timescale 1ns/1ps
module nvm_ctrl_checker (
    input wire logic CLK_IN,
    input wire logic RST_IN,
    input wire logic [15:0] ADDR_IN,
    input wire logic [7:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    input wire logic TEST_VOLTAGE_LEVEL_IN,
    input wire logic BOOT_SELECT_PIN_IN,
    input wire logic STOP_ENTRY_IN,
    input wire logic [7:0] RDATA_OUT,
    input wire logic BOOT_MODE_OUT,
    input wire logic [15:0] BOOT_VECTOR_OUT,
    input wire logic OTP_PROGRAM_POWER_OUT,
    input wire logic OPTION_PGM_OUT,
    input wire logic PUMP_ENABLE_OUT,
    input wire logic ERASABLE_POWER_OUT,
    input wire logic RC_OSC_ENABLE_OUT,
    input wire logic LVR_ENABLE_OUT,
    input wire logic STOP_ENABLE_OUT,
    input wire logic LEVEL_SENSE_OUT,
    input wire logic WATCHDOG_ENABLE_OUT
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);
    logic otp_hit;
    assign otp_hit = ADDR_IN >= nvm_ctrl_pkg::OTP_BASE_ADDR
        && ADDR_IN <= nvm_ctrl_pkg::OTP_LAST_ADDR;
    property p_boot_vector;
        BOOT_VECTOR_OUT == (BOOT_MODE_OUT ? nvm_ctrl_pkg::BOOT_START_ADDR : 16'h0000);
    endproperty
    a_boot_vector: assert property (p_boot_vector) else $error("boot vector wrong");
    property p_boot_entry;
        $fell(RST_IN) && TEST_VOLTAGE_LEVEL_IN && BOOT_SELECT_PIN_IN |-> ##2 BOOT_MODE_OUT;
    endproperty
    a_boot_entry: assert property (p_boot_entry) else $error("boot mode missed");
    // Clearing the latch must drop power two cycles on
    property p_power_drop;
        WR_IN && ADDR_IN == nvm_ctrl_pkg::OTP_CTRL_ADDR
            && !WDATA_IN[nvm_ctrl_pkg::OTP_LATCH_BIT] |-> ##2 !OTP_PROGRAM_POWER_OUT;
    endproperty
    a_power_drop: assert property (p_power_drop) else $error("otp power kept");
    property p_read_block;
        RD_IN && otp_hit && OTP_PROGRAM_POWER_OUT && !$past(WR_IN) |=> RDATA_OUT == 8'h00;
    endproperty
    a_read_block: assert property (p_read_block) else $error("otp read not blocked");
    property p_option_off;
        OPTION_PGM_OUT && $past(OPTION_PGM_OUT) |-> !LVR_ENABLE_OUT && !STOP_ENABLE_OUT
            && !LEVEL_SENSE_OUT && !WATCHDOG_ENABLE_OUT;
    endproperty
    a_option_off: assert property (p_option_off) else $error("options live");
    property p_pump_gate;
        ERASABLE_POWER_OUT |-> PUMP_ENABLE_OUT;
    endproperty
    a_pump_gate: assert property (p_pump_gate) else $error("power without pump");
    property p_stop_rc;
        STOP_ENTRY_IN && !WR_IN |-> ##2 !RC_OSC_ENABLE_OUT;
    endproperty
    a_stop_rc: assert property (p_stop_rc) else $error("rc left on in stop");
    property p_reset_clear;
        $fell(RST_IN) |-> !OTP_PROGRAM_POWER_OUT && !ERASABLE_POWER_OUT
            && !PUMP_ENABLE_OUT && !RC_OSC_ENABLE_OUT;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("reset left power");
    // No hidden timer: power moves only after a write
    property p_pulse_hold;
        !$past(WR_IN, 2) |-> $stable(ERASABLE_POWER_OUT);
    endproperty
    a_pulse_hold: assert property (p_pulse_hold) else $error("power moved alone");
    c_boot: cover property (BOOT_MODE_OUT);
    c_option: cover property (OPTION_PGM_OUT);
    c_ee_power: cover property (ERASABLE_POWER_OUT);
endmodule // nvm_ctrl_checker

bind nvm_program_ctrl nvm_ctrl_checker i_nvm_ctrl_checker (.CLK_IN, .RST_IN, .ADDR_IN,
    .WDATA_IN, .WR_IN, .RD_IN, .TEST_VOLTAGE_LEVEL_IN, .BOOT_SELECT_PIN_IN, .STOP_ENTRY_IN,
    .RDATA_OUT, .BOOT_MODE_OUT, .BOOT_VECTOR_OUT, .OTP_PROGRAM_POWER_OUT, .OPTION_PGM_OUT,
    .PUMP_ENABLE_OUT, .ERASABLE_POWER_OUT, .RC_OSC_ENABLE_OUT, .LVR_ENABLE_OUT,
    .STOP_ENABLE_OUT, .LEVEL_SENSE_OUT, .WATCHDOG_ENABLE_OUT);

// *** tb_nvm_program_ctrl.sv ***
// Self-checking bench of the program control block
`timescale 1ns/1ps
module tb_nvm_program_ctrl;
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic [7:0] rdata;
    } row_t;
    logic CLK_IN = 1'b0;
    logic RST_IN = 1'b1;
    logic WR_IN = 1'b0;
    logic RD_IN = 1'b0;
    logic TEST_VOLTAGE_LEVEL_IN = 1'b0;
    logic BOOT_SELECT_PIN_IN = 1'b0;
    logic STOP_ENTRY_IN = 1'b0;
    logic [15:0] ADDR_IN = 16'h0000;
    logic [7:0] WDATA_IN = 8'h00;
    logic [7:0] OTP_RDATA_IN = 8'h5A;
    logic [7:0] RDATA_OUT, OTP_PGM_DATA_OUT;
    logic [15:0] BOOT_VECTOR_OUT, OTP_PGM_ADDR_OUT;
    logic BOOT_MODE_OUT, OTP_PROGRAM_POWER_OUT, OPTION_PGM_OUT, PUMP_ENABLE_OUT;
    logic ERASABLE_POWER_OUT, RC_OSC_ENABLE_OUT, LVR_ENABLE_OUT, STOP_ENABLE_OUT;
    logic LEVEL_SENSE_OUT, WATCHDOG_ENABLE_OUT;
    int err_count = 0;
    int n_tests = 0;
    // Rows run in order: state carries from one to the next
    row_t rows [9] = '{'{16'h000D, 8'hFC, 8'h04}, '{16'h000E, 8'hFC, 8'h3C},
        '{16'h000E, 8'h29, 8'h28}, '{16'h000E, 8'h04, 8'h04}, '{16'h0010, 8'hAA, 8'h00},
        '{16'h3C00, 8'h0F, 8'h00}, '{16'h000D, 8'h00, 8'h00}, '{16'h3C00, 8'h0F, 8'h00},
        '{16'h000E, 8'h00, 8'h00}};

    nvm_program_ctrl i_nvm_program_ctrl (.CLK_IN, .RST_IN, .ADDR_IN, .WDATA_IN, .WR_IN, .RD_IN,
        .TEST_VOLTAGE_LEVEL_IN, .BOOT_SELECT_PIN_IN, .STOP_ENTRY_IN, .OTP_RDATA_IN, .RDATA_OUT,
        .BOOT_MODE_OUT, .BOOT_VECTOR_OUT, .OTP_PROGRAM_POWER_OUT, .OTP_PGM_ADDR_OUT,
        .OTP_PGM_DATA_OUT, .OPTION_PGM_OUT, .PUMP_ENABLE_OUT, .ERASABLE_POWER_OUT,
        .RC_OSC_ENABLE_OUT, .LVR_ENABLE_OUT, .STOP_ENABLE_OUT, .LEVEL_SENSE_OUT,
        .WATCHDOG_ENABLE_OUT);

    always #5 CLK_IN = ~CLK_IN;

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge CLK_IN);
        WR_IN <= 1'b1;
        ADDR_IN <= a;
        WDATA_IN <= d;
        @(posedge CLK_IN);
        WR_IN <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge CLK_IN);
        RD_IN <= 1'b1;
        ADDR_IN <= a;
        @(posedge CLK_IN);
        RD_IN <= 1'b0;
        #1;
        chk("read data", 16'(exp), 16'(RDATA_OUT));
    endtask
    // Outputs trail the register by one cycle
    task automatic settle;
        repeat (2) @(posedge CLK_IN);
        #1;
    endtask
    task automatic do_reset(input logic boot);
        TEST_VOLTAGE_LEVEL_IN <= boot;
        BOOT_SELECT_PIN_IN <= boot;
        RST_IN <= 1'b1;
        repeat (2) @(posedge CLK_IN);
        RST_IN <= 1'b0;
        repeat (3) @(posedge CLK_IN);
        #1;
    endtask
    // Latch and mode write, data write, power pulse, then release
    task automatic ee_op(input logic [7:0] c, input logic [15:0] a, input logic [7:0] d);
        wr(16'h000E, c);
        wr(a, d);
        wr(16'h000E, c | 8'h01);
        settle();
        chk("ee power", 16'h0001, 16'(ERASABLE_POWER_OUT));
        chk("pump", 16'h0001, 16'(PUMP_ENABLE_OUT));
        rd(a, 8'h00);
        wr(16'h000E, c);
        wr(16'h000E, 8'h00);
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        do_reset(1'b0);
        chk("boot mode", 16'h0000, 16'(BOOT_MODE_OUT));
        chk("watchdog", 16'h0001, 16'(WATCHDOG_ENABLE_OUT));
        chk("options", 16'h0000, 16'({LVR_ENABLE_OUT, STOP_ENABLE_OUT, LEVEL_SENSE_OUT}));
        $display("test reset done");
        foreach (rows[i]) begin
            wr(rows[i].addr, rows[i].wdata);
            rd(rows[i].addr, rows[i].rdata);
        end
        $display("test table done");
        rd(16'h1000, 8'h5A);
        wr(16'h000D, 8'h03);
        settle();
        chk("otp power", 16'h0000, 16'(OTP_PROGRAM_POWER_OUT));
        wr(16'h000D, 8'h02);
        wr(16'h1234, 8'h3C);
        settle();
        chk("otp addr", 16'h1234, OTP_PGM_ADDR_OUT);
        chk("otp data", 16'h003C, 16'(OTP_PGM_DATA_OUT));
        rd(16'h1000, 8'h00);
        wr(16'h000D, 8'h03);
        settle();
        chk("otp power", 16'h0001, 16'(OTP_PROGRAM_POWER_OUT));
        rd(16'h1000, 8'h00);
        wr(16'h000D, 8'h01);
        settle();
        chk("otp power", 16'h0000, 16'(OTP_PROGRAM_POWER_OUT));
        $display("test otp done");
        ee_op(8'h16, 16'h0250, 8'h00);
        rd(16'h0250, 8'hFF);
        ee_op(8'h12, 16'h0250, 8'hA5);
        rd(16'h0250, 8'hA5);
        ee_op(8'h1A, 16'h027F, 8'h00);
        rd(16'h0250, 8'hFF);
        ee_op(8'h1E, 16'h0333, 8'h00);
        rd(16'h0240, 8'hFF);
        wr(16'h000E, 8'h20);
        settle();
        chk("rc osc", 16'h0001, 16'(RC_OSC_ENABLE_OUT));
        @(posedge CLK_IN);
        STOP_ENTRY_IN <= 1'b1;
        @(posedge CLK_IN);
        STOP_ENTRY_IN <= 1'b0;
        rd(16'h000E, 8'h00);
        chk("rc osc", 16'h0000, 16'(RC_OSC_ENABLE_OUT));
        $display("test erasable done");
        wr(16'h000D, 8'h06);
        wr(16'h3C00, 8'hFE);
        wr(16'h000D, 8'h07);
        settle();
        chk("option pgm", 16'h0001, 16'(OPTION_PGM_OUT));
        chk("watchdog", 16'h0000, 16'(WATCHDOG_ENABLE_OUT));
        chk("options", 16'h0000, 16'({LVR_ENABLE_OUT, STOP_ENABLE_OUT, LEVEL_SENSE_OUT}));
        wr(16'h000D, 8'h04);
        rd(16'h3C00, 8'h0E);
        chk("options", 16'h0007, 16'({LVR_ENABLE_OUT, STOP_ENABLE_OUT, LEVEL_SENSE_OUT}));
        chk("watchdog", 16'h0001, 16'(WATCHDOG_ENABLE_OUT));
        // Second pass sets the inverted watchdog bit
        wr(16'h000D, 8'h06);
        wr(16'h3C00, 8'h01);
        wr(16'h000D, 8'h07);
        wr(16'h000D, 8'h04);
        rd(16'h3C00, 8'h0F);
        chk("watchdog", 16'h0000, 16'(WATCHDOG_ENABLE_OUT));
        wr(16'h000E, 8'h12);
        wr(16'h000E, 8'h13);
        do_reset(1'b1);
        chk("ee power", 16'h0000, 16'(ERASABLE_POWER_OUT));
        chk("pump", 16'h0000, 16'(PUMP_ENABLE_OUT));
        rd(16'h000E, 8'h00);
        chk("boot mode", 16'h0001, 16'(BOOT_MODE_OUT));
        chk("boot vector", 16'h3C00, BOOT_VECTOR_OUT);
        // Option cells return to erased on reset in this model
        chk("options", 16'h0000, 16'({LVR_ENABLE_OUT, STOP_ENABLE_OUT, LEVEL_SENSE_OUT}));
        chk("watchdog", 16'h0001, 16'(WATCHDOG_ENABLE_OUT));
        rd(16'h3C00, 8'h00);
        $display("test option done");
        stop_test();
    end

    // Whole run is under two hundred cycles
    initial begin
        #50000;
        err_count++;
        stop_test();
    end
endmodule // tb_nvm_program_ctrl
